// *** bench/arp_host.sv ***
// Host model: straps, strobes, serial clock and board pin levels
`timescale 1ns/1ps
module arp_host (
	// Device side
	input wire        clk_i,
	input wire [15:0] bus_i,
	input wire [15:0] oe_i,
	output reg        is_o,
	output reg        cs_n_o,
	output reg        rd_n_o,
	output wire [15:0] pins_o
);
	reg bsel_r = 1'b0;
	reg hbf_r = 1'b0;
	initial begin
		is_o = 1'b0;
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
	end
	// Unused lines tied to ground; undriven word lines pulled low
	assign pins_o = (bus_i & oe_i) | ({bsel_r, hbf_r, 14'h0000} & ~oe_i & {16{is_o}});
	task set_mode(input m, input bs, input hb);
		begin
			@(negedge clk_i);
			is_o = m;
			bsel_r = bs;
			hbf_r = hb;
			repeat (6) @(negedge clk_i);
		end
	endtask
	task par_read(output [15:0] d, output [15:0] oe);
		begin
			cs_n_o = 1'b0;
			rd_n_o = 1'b0;
			repeat (6) @(negedge clk_i);
			d = pins_o;
			oe = oe_i;
			rd_n_o = 1'b1;
			repeat (6) @(negedge clk_i);
			cs_n_o = 1'b1;
			repeat (6) @(negedge clk_i);
		end
	endtask
	task ser_read(output [15:0] a, output [15:0] b);
		integer i;
		begin
			cs_n_o = 1'b0;
			for (i = 15; i >= 0; i = i - 1) begin
				#62.5 rd_n_o = 1'b0;
				a[i] = pins_o[7];
				b[i] = pins_o[8];
				#62.5 rd_n_o = 1'b1;
			end
			repeat (6) @(negedge clk_i);
			cs_n_o = 1'b1;
			repeat (6) @(negedge clk_i);
		end
	endtask
endmodule

// *** bench/arp_port_chk.sv ***
// Assertion checker for the result output port
`timescale 1ns/1ps
`include "arp_defs.vh"
module arp_port_chk (
	// Watched ports
	input wire                   clk_i,
	input wire                   resetn_i,
	input wire                   interface_select_i,
	input wire                   device_select_n_i,
	input wire                   read_strobe_n_i,
	input wire                   results_load_i,
	input wire [`ARP_DATA_W-1:0] result_bus_i,
	input wire [`ARP_DATA_W-1:0] result_bus_oe_o,
	input wire                   byte_mode_o,
	input wire                   serial_mode_o,
	input wire [`ARP_CHAN_W-1:0] channel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	wire rd = !device_select_n_i && !read_strobe_n_i;
	AST_FLOAT: assert property (device_select_n_i [*6] |-> result_bus_oe_o == 16'h0000)
		else $error("bus driven while deselected");
	AST_WORD: assert property ((!interface_select_i && rd) [*6] |-> result_bus_oe_o == 16'hFFFF)
		else $error("word read not driven");
	AST_BYTE: assert property ((byte_mode_o && rd) [*6] |-> result_bus_oe_o == 16'h00FF)
		else $error("byte read lines wrong");
	AST_SER: assert property ((serial_mode_o && !device_select_n_i) [*6] |-> result_bus_oe_o == 16'h0180)
		else $error("serial lines not driven");
	AST_SER_OFF: assert property (serial_mode_o |-> (result_bus_oe_o & 16'hFE7F) == 16'h0000)
		else $error("serial drives extra lines");
	AST_MBYTE: assert property ((interface_select_i && result_bus_i[15]) [*4] |-> byte_mode_o)
		else $error("byte mode not selected");
	AST_MSER: assert property ((interface_select_i && !result_bus_i[15]) [*4] |-> serial_mode_o)
		else $error("serial mode not selected");
	AST_LOAD: assert property (results_load_i |=> channel_o == 3'h0)
		else $error("channel not restarted");
	cover property (byte_mode_o && result_bus_oe_o[7]);
	cover property (serial_mode_o && result_bus_oe_o[8]);
	cover property (result_bus_oe_o == 16'hFFFF);
endmodule
bind arp_port arp_port_chk u_chk (.*);

// *** bench/tb_arp_port.sv ***
// Self-checking bench for the result output port
`timescale 1ns/1ps
module tb_arp_port;
	reg          clk_i = 1'b0;
	reg          resetn_i = 1'b0;
	reg  [127:0] res_r = 128'h0;
	reg          load_r = 1'b0;
	wire [15:0]  bo, boe, bi;
	wire         is_w, cs_n, rd_n;
	integer      n_mismatch = 0;
	integer      num_checks = 0;
	integer      k, h;
	reg  [15:0]  a, b, e, v;
	always #4 clk_i = ~clk_i;
	arp_port dut (.clk_i(clk_i), .resetn_i(resetn_i), .interface_select_i(is_w),
		.device_select_n_i(cs_n), .read_strobe_n_i(rd_n), .results_i(res_r),
		.results_load_i(load_r), .result_bus_i(bi), .result_bus_o(bo),
		.result_bus_oe_o(boe), .byte_mode_o(), .serial_mode_o(), .channel_o());
	arp_host host (.clk_i(clk_i), .bus_i(bo), .oe_i(boe), .is_o(is_w), .cs_n_o(cs_n),
		.rd_n_o(rd_n), .pins_o(bi));
	function [15:0] val(input integer n);
		val = 16'hC35A ^ (16'h1111 * n[15:0]);
	endfunction
	task check(input [15:0] got, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task load;
		begin
			for (k = 0; k < 8; k = k + 1)
				res_r[k*16 +: 16] = val(k);
			@(negedge clk_i) load_r = 1'b1;
			@(negedge clk_i) load_r = 1'b0;
		end
	endtask
	task t_word;
		begin
			host.set_mode(1'b0, 1'b0, 1'b0);
			load;
			for (k = 0; k < 2; k = k + 1) begin
				host.par_read(a, e);
				check(e, 16'hFFFF);
				check(a, val(k));
			end
			check(boe, 16'h0000);
			$display("word test done");
		end
	endtask
	task t_byte;
		begin
			for (h = 0; h < 2; h = h + 1) begin
				host.set_mode(1'b1, 1'b1, h[0]);
				load;
				for (k = 0; k < 2; k = k + 1) begin
					v = val(k);
					host.par_read(a, e);
					host.par_read(b, e);
					check(e, 16'h00FF);
					check({a[7:0], b[7:0]}, h ? v : {v[7:0], v[15:8]});
				end
			end
			$display("byte test done");
		end
	endtask
	task t_ser;
		begin
			host.set_mode(1'b1, 1'b0, 1'b0);
			load;
			host.ser_read(a, b);
			check(a, val(0));
			check(b, val(4));
			$display("serial test done");
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (3) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge clk_i);
		t_word;
		t_byte;
		t_ser;
		end_sim;
	end
endmodule

// *** rtl/arp_defs.vh ***
// Constants for the converter result output port
`ifndef ARP_DEFS_VH
`define ARP_DEFS_VH
`define ARP_DATA_W      16
`define ARP_CHAN_N      8
`define ARP_CHAN_W      3
`define ARP_BIT_CNT_W   4
`define ARP_SER_HALF    4
`define ARP_SER_LAST    4'hF
`define ARP_BIT_SERA    7
`define ARP_BIT_SERB    8
`define ARP_BIT_HBF     14
`define ARP_BIT_BYTESEL 15
`endif

// *** rtl/arp_port.v ***
// Result output port: word, byte and dual-line serial readout
`timescale 1ns/1ps
`include "arp_defs.vh"
module arp_port (
	// Clock and reset
	input  wire                          clk_i,
	input  wire                          resetn_i,
	// Mode strap
	input  wire                          interface_select_i,
	// Host strobes
	input  wire                          device_select_n_i,
	input  wire                          read_strobe_n_i,
	// Conversion results, eight channels packed, channel 0 in low bits
	input  wire [`ARP_CHAN_N*`ARP_DATA_W-1:0] results_i,
	input  wire                          results_load_i,
	// Result bus pins
	input  wire [`ARP_DATA_W-1:0]        result_bus_i,
	output reg  [`ARP_DATA_W-1:0]        result_bus_o,
	output reg  [`ARP_DATA_W-1:0]        result_bus_oe_o,
	// Status
	output wire                          byte_mode_o,
	output wire                          serial_mode_o,
	output wire [`ARP_CHAN_W-1:0]        channel_o
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	wire cs_lvl;
	wire cs_fall;
	wire cs_rise;
	wire rd_lvl;
	wire rd_rise;
	wire ifs_lvl;
	wire bsel_lvl;
	wire hbf_lvl;
	wire sclk_rise;

	arp_sync u_cs (.clk_i(clk_i), .resetn_i(resetn_i), .async_i(device_select_n_i),
		.level_o(cs_lvl), .rise_o(cs_rise), .fall_o(cs_fall));
	arp_sync u_rd (.clk_i(clk_i), .resetn_i(resetn_i), .async_i(read_strobe_n_i),
		.level_o(rd_lvl), .rise_o(rd_rise), .fall_o());
	arp_sync u_ifs (.clk_i(clk_i), .resetn_i(resetn_i), .async_i(interface_select_i),
		.level_o(ifs_lvl), .rise_o(), .fall_o());
	arp_sync u_bsel (.clk_i(clk_i), .resetn_i(resetn_i),
		.async_i(result_bus_i[`ARP_BIT_BYTESEL]),
		.level_o(bsel_lvl), .rise_o(), .fall_o());
	arp_sync u_hbf (.clk_i(clk_i), .resetn_i(resetn_i),
		.async_i(result_bus_i[`ARP_BIT_HBF]),
		.level_o(hbf_lvl), .rise_o(), .fall_o());
	// Serial clock shares the read strobe pin
	arp_sync u_sclk (.clk_i(clk_i), .resetn_i(resetn_i), .async_i(read_strobe_n_i),
		.level_o(), .rise_o(sclk_rise), .fall_o());

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	localparam [2:0] ST_WORD   = 3'h1;
	localparam [2:0] ST_BYTE   = 3'h2;
	localparam [2:0] ST_SERIAL = 3'h4;

	reg  [2:0] mode;
	always @* begin
		if (!ifs_lvl)
			mode = ST_WORD;
		else if (bsel_lvl)
			mode = ST_BYTE;
		else
			mode = ST_SERIAL;
	end

	assign byte_mode_o   = (mode == ST_BYTE);
	assign serial_mode_o = (mode == ST_SERIAL);

	// ------------------------------------------------------------
	// Result store and read state
	// ------------------------------------------------------------
	reg [`ARP_DATA_W-1:0]   res_r [0:`ARP_CHAN_N-1];
	reg [`ARP_CHAN_W-1:0]   chan_r;
	reg                     second_r;
	reg [`ARP_DATA_W-1:0]   shift_a_r;
	reg [`ARP_DATA_W-1:0]   shift_b_r;
	reg [`ARP_BIT_CNT_W-1:0] bit_cnt_r;
	integer i;

	assign channel_o = chan_r;

	function [`ARP_DATA_W-1:0] arp_pick;
		input [`ARP_CHAN_N*`ARP_DATA_W-1:0] bus;
		input [`ARP_CHAN_W-1:0]             idx;
		begin
			arp_pick = bus[idx*`ARP_DATA_W +: `ARP_DATA_W];
		end
	endfunction

	// Channel index wraps after the last channel
	function [`ARP_CHAN_W-1:0] arp_inc;
		input [`ARP_CHAN_W-1:0] idx;
		begin
			arp_inc = idx + 3'h1;
		end
	endfunction

	wire                   read_act = ~cs_lvl & ~rd_lvl;
	wire [`ARP_DATA_W-1:0] cur      = res_r[chan_r];
	wire [`ARP_CHAN_W-1:0] chan_b   = chan_r + 3'h4;
	wire                   ser_on   = (mode == ST_SERIAL) & ~results_load_i;
	wire                   ser_load = ser_on & cs_fall;
	wire                   ser_step = ser_on & ~cs_fall & ~cs_lvl & sclk_rise;
	wire                   ser_wrap = ser_step & (bit_cnt_r == `ARP_SER_LAST);

	// ------------------------------------------------------------
	// Serial shifters
	// ------------------------------------------------------------
	// Pins follow the next value, so no stale bit shows after select falls
	reg [`ARP_DATA_W-1:0]    shift_a_nxt;
	reg [`ARP_DATA_W-1:0]    shift_b_nxt;
	reg [`ARP_BIT_CNT_W-1:0] bit_cnt_nxt;

	always @* begin
		shift_a_nxt = shift_a_r;
		shift_b_nxt = shift_b_r;
		bit_cnt_nxt = bit_cnt_r;
		if (ser_load) begin
			// Line A carries channel chan_r, line B chan_b four above: lower and upper half for the first four words
			shift_a_nxt = res_r[chan_r];
			shift_b_nxt = res_r[chan_b];
			bit_cnt_nxt = 4'h0;
		end else if (ser_step) begin
			bit_cnt_nxt = bit_cnt_r + 4'h1;
			if (ser_wrap) begin
				// Sixteen bits sent: next channel follows without a gap
				shift_a_nxt = res_r[arp_inc(chan_r)];
				shift_b_nxt = res_r[arp_inc(chan_b)];
			end else begin
				shift_a_nxt = {shift_a_r[`ARP_DATA_W-2:0], 1'b0};
				shift_b_nxt = {shift_b_r[`ARP_DATA_W-2:0], 1'b0};
			end
		end
	end

	// ------------------------------------------------------------
	// Channel, byte phase and shifter registers
	// ------------------------------------------------------------
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (i = 0; i < `ARP_CHAN_N; i = i + 1)
				res_r[i] <= 16'h0000;
			chan_r    <= 3'h0;
			second_r  <= 1'b0;
			shift_a_r <= 16'h0000;
			shift_b_r <= 16'h0000;
			bit_cnt_r <= 4'h0;
		end else begin
			shift_a_r <= shift_a_nxt;
			shift_b_r <= shift_b_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			if (results_load_i) begin
				for (i = 0; i < `ARP_CHAN_N; i = i + 1)
					res_r[i] <= arp_pick(results_i, i[`ARP_CHAN_W-1:0]);
				chan_r   <= 3'h0;
				second_r <= 1'b0;
			end else if (mode == ST_WORD && !cs_lvl && rd_rise) begin
				chan_r <= arp_inc(chan_r);
			end else if (mode == ST_BYTE && !cs_lvl && rd_rise) begin
				second_r <= ~second_r;
				if (second_r)
					chan_r <= arp_inc(chan_r);
			end else if (ser_wrap) begin
				chan_r <= arp_inc(chan_r);
			end else if (mode == ST_SERIAL && cs_rise) begin
				chan_r <= 3'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	wire hbf_now = hbf_lvl;
	wire upper   = hbf_now ^ second_r;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			result_bus_o    <= 16'h0000;
			result_bus_oe_o <= 16'h0000;
		end else begin
			result_bus_o    <= 16'h0000;
			result_bus_oe_o <= 16'h0000;
			case (mode)
			ST_WORD: begin
				if (read_act) begin
					// Includes line 7 and line 14 during a read
					result_bus_o    <= cur;
					result_bus_oe_o <= 16'hFFFF;
				end
			end
			ST_BYTE: begin
				if (read_act) begin
					// Lines 14 and 15 stay inputs; others tied low by host
					result_bus_o[7:0]    <= upper ? cur[15:8] : cur[7:0];
					result_bus_oe_o[7:0] <= 8'hFF;
				end
			end
			ST_SERIAL: begin
				if (!cs_lvl) begin
					result_bus_o[`ARP_BIT_SERA]    <= shift_a_nxt[`ARP_DATA_W-1];
					result_bus_o[`ARP_BIT_SERB]    <= shift_b_nxt[`ARP_DATA_W-1];
					result_bus_oe_o[`ARP_BIT_SERA] <= 1'b1;
					result_bus_oe_o[`ARP_BIT_SERB] <= 1'b1;
				end
			end
			default: begin
				result_bus_o    <= 16'h0000;
				result_bus_oe_o <= 16'h0000;
			end
			endcase
		end
	end
endmodule

// *** rtl/arp_sync.v ***
// Two-flop synchroniser with edge detect on the synchronised level
`timescale 1ns/1ps
module arp_sync (
	// Clock and reset
	input  wire clk_i,
	input  wire resetn_i,
	// Asynchronous level in
	input  wire async_i,
	// Synchronised level and edges
	output wire level_o,
	output wire rise_o,
	output wire fall_o
);
	reg meta_r;
	reg sync_r;
	reg last_r;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			last_r <= 1'b1;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign level_o = sync_r;
	assign rise_o  = sync_r & ~last_r;
	assign fall_o  = ~sync_r & last_r;
endmodule
